// [logic/wbc_pkg.sv]
package wbc_pkg;

  // ----------------------------------------------------------------
  // characters
  // ----------------------------------------------------------------
  localparam logic [7:0] CH_HASH  = 8'h23;
  localparam logic [7:0] CH_A     = 8'h41;
  localparam logic [7:0] CH_L     = 8'h4C;
  localparam logic [7:0] CH_I     = 8'h49;
  localparam logic [7:0] CH_COMMA = 8'h2C;
  localparam logic [7:0] CH_CR    = 8'h0D;
  localparam logic [7:0] CH_LF    = 8'h0A;
  localparam logic [7:0] CH_D0    = 8'h30;
  localparam logic [7:0] CH_D9    = 8'h39;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // limits and sizes
  // ----------------------------------------------------------------
  localparam logic [16:0] BYTE_MAX = 17'h0_00FF;
  localparam logic [16:0] WORD_MAX = 17'h0_FFFF;
  localparam logic [16:0] NUM_SAT  = 17'h1_FFFF;
  localparam logic [20:0] NUM_BASE = 21'h00_000A;
  localparam logic [15:0] BUF_LEN  = 16'h7D00;
  localparam logic [15:0] IVL_ONE  = 16'h0001;
  localparam logic [15:0] DESC_VAL_MAX = 16'h7FFF;
  localparam int          DESC_DEPTH = 16;
  localparam int          TIME_DEPTH = 8;
  localparam logic [16:0] DESC_N = 17'(DESC_DEPTH);
  localparam logic [16:0] TIME_N = 17'(TIME_DEPTH);
  localparam logic [7:0]  SYN_INV_HDR = 8'h0B;
  localparam logic [1:0]  PH_DESC = 2'h0;
  localparam logic [1:0]  PH_DATA = 2'h1;
  localparam logic [1:0]  PH_TIME = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    K_NONE = 3'h0, K_DESC = 3'h1, K_DATA = 3'h2, K_TIME = 3'h3, K_ALL = 3'h4
  } wbc_kind_t;

  typedef enum logic [8:0] {
    S_IDLE  = 9'h001, S_HASH   = 9'h002, S_ASC  = 9'h004,
    S_BCNT  = 9'h008, S_BVAL   = 9'h010, S_TRAIL = 9'h020,
    S_ENDCHK = 9'h040, S_FILL  = 9'h080, S_PURGE = 9'h100
  } wbc_state_t;

  typedef logic [15:0] wbc_word_t;
  typedef wbc_word_t [DESC_DEPTH-1:0] wbc_desc_t;
  typedef wbc_word_t [TIME_DEPTH-1:0] wbc_time_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } wbc_byte_t;

  typedef struct packed {
    logic      valid;
    wbc_kind_t kind;
    logic [15:0] intval;
    logic        cnt_given;
    logic [15:0] cnt;
    logic [15:0] addr;
  } wbc_wcmd_t;

  typedef struct packed {
    logic      valid;
    logic [15:0] addr;
    wbc_word_t   data;
  } wbc_bwr_t;

  typedef struct packed {
    logic adapted;
    logic bad_blk;
    logic syn_err;
    logic cmd_abort;
    logic desc_commit;
    logic time_commit;
  } wbc_evt_t;

  typedef struct packed {
    logic [15:0] ivl;
    logic [15:0] addr;
    logic [15:0] req;
    logic        adapted;
  } wbc_prm_t;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic wbc_kind_t wbc_tgt(input wbc_kind_t k, input logic [1:0] ph);
    if (k != K_ALL)
      return k;
    return (ph == PH_DESC) ? K_DESC : ((ph == PH_DATA) ? K_DATA : K_TIME);
  endfunction

endpackage

// [logic/wbc_stage.sv]
`timescale 1ns/1ps
module wbc_stage
  import wbc_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // staging write
  input  wire logic       wr,
  input  wire logic [3:0] idx,
  input  wire wbc_word_t  val,
  // commits
  input  wire logic       commit_desc,
  input  wire logic       commit_time,
  // stored contents
  output wbc_desc_t       desc_q,
  output wbc_time_t       time_q
);

  typedef struct packed {
    wbc_desc_t stg;
    wbc_desc_t dsc;
    wbc_time_t tim;
  } wbc_stg_t;

  wbc_stg_t s_reg;
  wbc_stg_t s_next;

  // ----------------------------------------------------------------
  // staging and commit
  // ----------------------------------------------------------------
  // stored copies change only on commit, so a rejected block leaves no trace
  always_comb
  begin
    s_next = s_reg;
    if (wr)
      s_next.stg[idx] = val;
    if (commit_desc)
      s_next.dsc = s_reg.stg;
    if (commit_time)
      for (int i = 0; i < TIME_DEPTH; i++)
        s_next.tim[i] = s_reg.stg[i];
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign desc_q = s_reg.dsc;
  assign time_q = s_reg.tim;

endmodule // wbc_stage

// [logic/wbc_checker.sv]
// Our own choices: the address-and-strobe port.
`timescale 1ns/1ps
// Function
// [RL1] data values written to buffer on arrival
// [RL2] adjusted parameter sets value-adapted flag
// [RL3] data count mismatch within sweep sets adapted
// [RL4] unknown preamble raises bad-block error
// [RL5] preamble count above limit raises error
// [RL6] received count unlike preamble raises error
// [RL7] ascii list allows digits, comma, cr, lf
// [RL8] ascii value above byte/word maximum errs
// [RL9] wrong count for descriptor or time errs
// [RL10] non-hash string where block expected errs
// [RL11] surplus blocks for command raise error
// [RL12] after error, purge until end block/command
// [RL13] command instead of block aborts transfer
// [RL14] block without write command: syntax error 11
// [RL15] host ends each block with legal trailer
// [RL16] descriptor values range checked, whole block rejected
// [RL17] time block with wrong count rejected
// [RL18] host sends descriptor, data, then time
// [RL19] host sends nominal plus one data values
// [RL20] full-waveform parameters checked after descriptor
// [RL21] stride above one fills points by interpolation
// [RL22] descriptor/time committed only when complete, valid
// [RL23] byte handshake, stalled during buffer writes
module wbc_checker
  import wbc_pkg::*;
(
  // clock and reset
  input  wire logic      clk,
  input  wire logic      rst,
  // write command from the decoder
  input  wire wbc_wcmd_t wcmd,
  // transfer setup
  input  wire logic      cfg_word,
  input  wire logic      cfg_no_end,
  // character stream
  input  wire wbc_byte_t rx,
  output logic           rx_ready,
  // waveform buffer port
  output wbc_bwr_t       bwr,
  input  wire logic      buf_ready,
  // committed descriptor and times
  output wbc_desc_t      desc_q,
  output wbc_time_t      time_q,
  // events
  output wbc_evt_t       evt,
  output logic [7:0]     syn_code
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    wbc_state_t  st;
    wbc_state_t  ret;
    wbc_kind_t   kind;
    logic [1:0]  ph;
    logic        at_start;
    logic        last_hash;
    logic        is_end;
    logic        cnt_done;
    logic        ndig;
    logic        hi_pend;
    logic        bad_vals;
    logic        have_prev;
    logic        blk_seen;
    logic [7:0]  hi_byte;
    logic [16:0] num;
    logic [16:0] pcnt;
    logic [16:0] rcnt;
    logic [16:0] tot;
    wbc_wcmd_t   cmd;
    wbc_prm_t    prm;
    logic [15:0] ptr;
    wbc_word_t   prev;
    wbc_word_t   cur;
    logic [15:0] fj;
    wbc_bwr_t    bw;
    logic        sw;
    logic [3:0]  sidx;
    wbc_word_t   sval;
    logic        rx_ready;
    wbc_evt_t    evt;
    logic [7:0]  syn_code;
  } wbc_core_t;

  wbc_core_t s_reg;
  wbc_core_t s_next;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // clamps the write parameters; any change is reported as adapted
  function automatic wbc_prm_t wbc_check(input wbc_wcmd_t c);
    wbc_prm_t    p;
    logic [15:0] rem;
    p.adapted = 1'b0;
    p.ivl = c.intval;
    p.addr = c.addr;
    if (c.intval == 16'h0000)
    begin
      p.ivl = IVL_ONE;
      p.adapted = 1'b1;
    end
    if (c.addr >= BUF_LEN)
    begin
      p.addr = BUF_LEN - IVL_ONE;
      p.adapted = 1'b1;
    end
    rem = BUF_LEN - p.addr;
    p.req = c.cnt_given ? c.cnt : rem;
    if (c.cnt_given && (c.cnt > rem))
    begin
      p.req = rem;
      p.adapted = 1'b1;
    end
    return p;
  endfunction

  function automatic logic [16:0] wbc_acc(input logic [16:0] num, input logic [7:0] ch);
    logic [20:0] t;
    t = 21'(num) * NUM_BASE + 21'(ch - CH_D0);
    return (t > 21'(NUM_SAT)) ? NUM_SAT : t[16:0];
  endfunction

  function automatic logic wbc_over(input wbc_kind_t t, input logic [16:0] cnt,
                                    input logic [15:0] rem);
    if (t == K_DESC)
      return cnt > DESC_N;
    if (t == K_TIME)
      return cnt > TIME_N;
    return cnt > {1'b0, rem};
  endfunction

  // weighted mean; the sum stays below 2**32 since the weights add to d
  function automatic wbc_word_t wbc_lerp(input wbc_word_t a, input wbc_word_t b,
                                         input logic [15:0] j, input logic [15:0] d);
    logic [32:0] t;
    t = 33'(a) * 33'(d - j) + 33'(b) * 33'(j);
    return 16'(t / 33'(d));
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic        acc;
  logic        eol;
  logic        dig;
  logic        take;
  logic        fault;
  logic        end_sec;
  logic [7:0]  c;
  wbc_word_t   v;
  wbc_kind_t   tgt;
  logic [15:0] rem;
  logic [16:0] lim;
  wbc_prm_t    p;

  always_comb
  begin
    s_next = s_reg;
    c = rx.data;
    acc = rx.valid && s_reg.rx_ready;
    eol = (c == CH_CR) || (c == CH_LF);
    dig = (c >= CH_D0) && (c <= CH_D9);
    tgt = wbc_tgt(s_reg.kind, s_reg.ph);
    rem = BUF_LEN - s_reg.ptr;
    lim = cfg_word ? WORD_MAX : BYTE_MAX;
    take = 1'b0;
    fault = 1'b0;
    end_sec = 1'b0;
    v = s_reg.num[15:0];
    p = wbc_check(wcmd.valid ? wcmd : s_reg.cmd);
    s_next.evt = '0;
    s_next.sw = 1'b0;
    if (s_reg.bw.valid && buf_ready)
      s_next.bw.valid = 1'b0;
    if (acc)
    begin
      s_next.at_start = eol;
      s_next.last_hash = s_reg.at_start && (c == CH_HASH);
    end
    if (wcmd.valid)
    begin
      s_next.kind = wcmd.kind;
      s_next.cmd = wcmd;
      s_next.ph = PH_DESC;
      s_next.blk_seen = 1'b0;
      s_next.st = S_IDLE;
      s_next.prm = p;
      s_next.ptr = p.addr;
      s_next.tot = '0;
      s_next.have_prev = 1'b0;
      // full-waveform parameters wait for the descriptor
      if (wcmd.kind != K_ALL)
        s_next.evt.adapted = p.adapted;                          // see [RL2] [RL20]
    end
    else
    begin
      unique case (s_reg.st)
        S_IDLE:
          if (acc && s_reg.at_start && !eol)
          begin
            if (c == CH_HASH && s_reg.kind == K_NONE)
            begin
              s_next.evt.syn_err = 1'b1;                         // see [RL14]
              s_next.syn_code = SYN_INV_HDR;
              s_next.st = S_PURGE;
            end
            else if (c == CH_HASH)
              s_next.st = S_HASH;
            else if (s_reg.kind != K_NONE)
            begin
              s_next.evt.bad_blk = 1'b1;                         // see [RL10]
              s_next.evt.cmd_abort = 1'b1;                       // see [RL13]
              s_next.kind = K_NONE;
            end
          end
        S_HASH:
          if (acc)
          begin
            s_next.num = '0;
            s_next.pcnt = '0;
            s_next.rcnt = '0;
            s_next.ndig = 1'b0;
            s_next.cnt_done = 1'b0;
            s_next.hi_pend = 1'b0;
            s_next.bad_vals = 1'b0;
            s_next.is_end = (c == CH_I);
            if (c == CH_I)
              s_next.st = S_TRAIL;
            else if (c != CH_A && c != CH_L)
              fault = 1'b1;                                      // see [RL4]
            else if (s_reg.blk_seen && tgt != K_DATA)
              fault = 1'b1;                                      // see [RL11]
            else
              s_next.st = (c == CH_L) ? S_ASC : S_BCNT;
          end
        S_ASC:
          if (acc)
          begin
            if (dig)
            begin
              s_next.num = wbc_acc(s_reg.num, c);
              s_next.ndig = 1'b1;
            end
            else if (c == CH_COMMA || eol)
            begin
              s_next.num = '0;
              s_next.ndig = 1'b0;
              if (eol)
                s_next.st = S_ENDCHK;
              if (s_reg.ndig && !s_reg.cnt_done)
              begin
                s_next.pcnt = s_reg.num;
                s_next.cnt_done = 1'b1;
                fault = wbc_over(tgt, s_reg.num, rem);           // see [RL5]
              end
              else if (s_reg.ndig && s_reg.num > lim)
                fault = 1'b1;                                    // see [RL8]
              else if (s_reg.ndig)
                take = 1'b1;
            end
            else
              fault = 1'b1;                                      // see [RL7]
          end
        S_BCNT:
          if (acc && !s_reg.hi_pend)
          begin
            s_next.hi_byte = c;
            s_next.hi_pend = 1'b1;
          end
          else if (acc)
          begin
            s_next.hi_pend = 1'b0;
            s_next.pcnt = {1'b0, s_reg.hi_byte, c};
            s_next.cnt_done = 1'b1;
            fault = wbc_over(tgt, {1'b0, s_reg.hi_byte, c}, rem); // see [RL5]
            s_next.st = ({s_reg.hi_byte, c} == 16'h0000) ? S_TRAIL : S_BVAL;
          end
        S_BVAL:
          if (acc && cfg_word && !s_reg.hi_pend)
          begin
            s_next.hi_byte = c;
            s_next.hi_pend = 1'b1;
          end
          else if (acc)
          begin
            s_next.hi_pend = 1'b0;
            v = cfg_word ? {s_reg.hi_byte, c} : {BYTE_ZERO, c};
            take = 1'b1;
            if (s_reg.rcnt + 17'h0_0001 == s_reg.pcnt)
              s_next.st = S_TRAIL;
          end
        S_TRAIL:
          if (acc && eol)
            s_next.st = S_ENDCHK;                                // see [RL15]
          else if (acc)
            fault = 1'b1;                                        // see [RL6]
        S_FILL:
          if (!s_reg.bw.valid || buf_ready)
          begin
            s_next.bw.valid = 1'b1;
            if (s_reg.fj == s_reg.prm.ivl)
            begin
              s_next.bw.addr = s_reg.ptr;
              s_next.bw.data = s_reg.cur;
              s_next.prev = s_reg.cur;
              s_next.ptr = s_reg.ptr + s_reg.prm.ivl;
              s_next.st = s_reg.ret;
            end
            else
            begin
              s_next.bw.addr = s_reg.ptr - s_reg.prm.ivl + s_reg.fj;
              s_next.bw.data = wbc_lerp(s_reg.prev, s_reg.cur, s_reg.fj,
                                        s_reg.prm.ivl);          // see [RL21]
              s_next.fj = s_reg.fj + IVL_ONE;
            end
            if (s_next.bw.addr >= BUF_LEN)
              s_next.bw.valid = 1'b0;
          end
        S_ENDCHK:
        begin
          s_next.st = S_IDLE;
          if (s_reg.is_end)
          begin
            end_sec = 1'b1;
            fault = !s_reg.blk_seen && tgt != K_DATA;            // see [RL9]
          end
          else
          begin
            s_next.blk_seen = 1'b1;
            end_sec = cfg_no_end;
            if (s_reg.rcnt != s_reg.pcnt)
              fault = 1'b1;                                      // see [RL6]
            else if (tgt == K_DATA)
              s_next.tot = s_reg.tot + s_reg.rcnt;
            else if (s_reg.bad_vals ||
                     s_reg.rcnt != ((tgt == K_DESC) ? DESC_N : TIME_N))
              fault = 1'b1;                                      // see [RL9] [RL16] [RL17]
            else
            begin
              s_next.evt.desc_commit = (tgt == K_DESC);          // see [RL22]
              s_next.evt.time_commit = (tgt == K_TIME);
            end
          end
          if (end_sec && !fault)
          begin
            if (tgt == K_DATA && s_next.tot != {1'b0, s_reg.prm.req} &&
                s_next.tot <= {1'b0, BUF_LEN - s_reg.prm.addr})
              s_next.evt.adapted = 1'b1;                         // see [RL3]
            // sections follow in the fixed host order
            if (s_reg.kind == K_ALL && s_reg.ph != PH_TIME)      // see [RL18]
            begin
              s_next.ph = s_reg.ph + 2'h1;
              s_next.blk_seen = 1'b0;
              if (s_reg.ph == PH_DESC)
              begin
                s_next.prm = p;
                s_next.ptr = p.addr;
                s_next.tot = '0;
                s_next.have_prev = 1'b0;
                s_next.evt.adapted = p.adapted;                  // see [RL2] [RL20]
              end
            end
            else
              s_next.kind = K_NONE;
          end
        end
        S_PURGE:
          // binary payload bytes can mimic an end block; accepted limitation
          if (acc && s_reg.last_hash && c == CH_I)
          begin
            s_next.kind = K_NONE;                                // see [RL12]
            s_next.st = S_IDLE;
          end
          else if (acc && s_reg.at_start && !eol && c != CH_HASH)
          begin
            s_next.kind = K_NONE;                                // see [RL12] [RL13]
            s_next.evt.cmd_abort = 1'b1;
            s_next.st = S_IDLE;
          end
      endcase
      // ------------------------------------------------------------
      // value handling
      // ------------------------------------------------------------
      if (take)
      begin
        s_next.rcnt = s_reg.rcnt + 17'h0_0001;
        if (s_reg.rcnt >= s_reg.pcnt)
          fault = 1'b1;                                          // see [RL6]
        else if (tgt != K_DATA)
        begin
          s_next.sw = (s_reg.rcnt < ((tgt == K_DESC) ? DESC_N : TIME_N));
          s_next.sidx = s_reg.rcnt[3:0];
          s_next.sval = v;
          if (tgt == K_DESC && v > DESC_VAL_MAX)
            s_next.bad_vals = 1'b1;                              // see [RL16]
        end
        else if (s_reg.have_prev && s_reg.prm.ivl != IVL_ONE)
        begin
          s_next.cur = v;                                        // see [RL21]
          s_next.fj = IVL_ONE;
          s_next.ret = s_next.st;
          s_next.st = S_FILL;
        end
        else
        begin
          s_next.bw.valid = (s_reg.ptr < BUF_LEN);               // see [RL1]
          s_next.bw.addr = s_reg.ptr;
          s_next.bw.data = v;
          s_next.prev = v;
          s_next.have_prev = 1'b1;
          s_next.ptr = s_reg.ptr + s_reg.prm.ivl;
        end
      end
      if (fault)
      begin
        s_next.evt.bad_blk = 1'b1;                               // see [RL12]
        s_next.st = S_PURGE;
      end
    end
    // the sender waits while a buffer write or an internal step is pending
    s_next.rx_ready = !s_next.bw.valid &&
                      s_next.st != S_FILL && s_next.st != S_ENDCHK; // see [RL23]
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_reg <= '0;
      s_reg.st <= S_IDLE;
      s_reg.ret <= S_IDLE;
      s_reg.at_start <= 1'b1;
    end
    else
      s_reg <= s_next;
  end

  // ----------------------------------------------------------------
  // staging store
  // ----------------------------------------------------------------
  wbc_stage u_stage (
    .clk         (clk),
    .rst         (rst),
    .wr          (s_reg.sw),
    .idx         (s_reg.sidx),
    .val         (s_reg.sval),
    .commit_desc (s_reg.evt.desc_commit),
    .commit_time (s_reg.evt.time_commit),
    .desc_q      (desc_q),
    .time_q      (time_q)
  );

  assign rx_ready = s_reg.rx_ready;
  assign bwr      = s_reg.bw;
  assign evt      = s_reg.evt;
  assign syn_code = s_reg.syn_code;

endmodule // wbc_checker

// [testbench/wbc_buf_model.sv]
`timescale 1ns/1ps
module wbc_buf_model
  import wbc_pkg::*;
(
  // clock and reset
  input  wire logic     clk,
  input  wire logic     rst,
  // buffer port
  input  wire wbc_bwr_t bwr,
  output logic          buf_ready
);
  wbc_word_t  mem [0:63];
  logic [1:0] ph;
  // stall one cycle in four so writes must hold
  always_ff @(posedge clk)
  begin
    if (rst)
      ph <= 2'h0;
    else
    begin
      ph <= ph + 2'h1;
      if (bwr.valid && buf_ready && bwr.addr < 16'h0040)
        mem[bwr.addr[5:0]] <= bwr.data;
    end
  end
  assign buf_ready = (ph != 2'h3);
endmodule // wbc_buf_model

// [testbench/wbc_checker_asserts.sv]
`timescale 1ns/1ps
module wbc_checker_asserts
  import wbc_pkg::*;
(
  // watched ports
  input wire logic       clk,
  input wire logic       rst,
  input wire wbc_wcmd_t  wcmd,
  input wire logic       cfg_word,
  input wire logic       cfg_no_end,
  input wire wbc_byte_t  rx,
  input wire logic       rx_ready,
  input wire wbc_bwr_t   bwr,
  input wire logic       buf_ready,
  input wire wbc_desc_t  desc_q,
  input wire wbc_time_t  time_q,
  input wire wbc_evt_t   evt,
  input wire logic [7:0] syn_code
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_stall;
    bwr.valid && !buf_ready;
  endsequence
  sequence s_clamp;
    wcmd.valid && wcmd.kind == K_DATA && wcmd.intval == 16'h0000;
  endsequence
  a_ready_low: assert property (bwr.valid |-> !rx_ready)
    else $error("ready high while write pends");
  a_write_hold: assert property (s_stall |=> bwr.valid && $stable(bwr.addr)
    && $stable(bwr.data))
    else $error("pending write changed");
  a_write_range: assert property (bwr.valid |-> bwr.addr < BUF_LEN)
    else $error("write beyond buffer");
  a_code_set: assert property (evt.syn_err |-> syn_code == SYN_INV_HDR)
    else $error("syntax code wrong");
  a_code_stick: assert property (syn_code == SYN_INV_HDR |=> syn_code == SYN_INV_HDR)
    else $error("syntax code lost");
  a_desc_only: assert property (!$stable(desc_q) |-> $past(evt.desc_commit))
    else $error("descriptor changed without commit");
  a_time_only: assert property (!$stable(time_q) |-> $past(evt.time_commit))
    else $error("times changed without commit");
  a_commit_ok: assert property (evt.desc_commit || evt.time_commit |-> !evt.bad_blk)
    else $error("commit with error");
  a_clamp_flag: assert property (s_clamp |=> evt.adapted)
    else $error("clamp not flagged");
endmodule // wbc_checker_asserts
bind wbc_checker wbc_checker_asserts i_asserts (.clk, .rst, .wcmd, .cfg_word, .cfg_no_end,
  .rx, .rx_ready, .bwr, .buf_ready, .desc_q, .time_q, .evt, .syn_code);

// [testbench/waveform_block_write_checker_tb_top.sv]
`timescale 1ns/1ps
module waveform_block_write_checker_tb_top;
  import wbc_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       clr = 1'b0;
  wbc_wcmd_t  wcmd = '0;
  logic       cfg_word = 1'b0;
  logic       cfg_no_end = 1'b1;
  wbc_byte_t  rx = '0;
  logic       rx_ready;
  wbc_bwr_t   bwr;
  logic       buf_ready;
  wbc_desc_t  desc_q;
  wbc_time_t  time_q;
  wbc_evt_t   evt;
  wbc_evt_t   seen;
  logic [7:0] syn_code;
  int         err_count = 0;
  int         checks = 0;
  string      bad [5] = '{"#L,1,256\015", "#Q\015", "#L,1,4x\015", "#L,40000\015",
                          "#L,2,7\015"};
  always #5 clk = ~clk;
  // pulses are one cycle, keep them until read
  always @(posedge clk) seen <= (rst || clr) ? '0 : (seen | evt);
  wbc_checker i_dut (.clk, .rst, .wcmd, .cfg_word, .cfg_no_end, .rx, .rx_ready, .bwr,
    .buf_ready, .desc_q, .time_q, .evt, .syn_code);
  wbc_buf_model i_buf (.clk, .rst, .bwr, .buf_ready);
  task automatic ck(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic snd(input logic [7:0] b);
    int   n;
    logic r;
    rx <= '{1'b1, b};
    n = 0;
    do
    begin
      @(negedge clk);
      r = rx_ready;
      @(posedge clk);
      n++;
    end while (r !== 1'b1 && n < 100);
    if (n >= 100)
    begin
      err_count++;
      tally_and_finish();
    end
  endtask
  task automatic str(input string s);
    for (int i = 0; i < s.len(); i++) snd(s[i]);
  endtask
  task automatic idle;
    rx <= '0;
    repeat (6) @(posedge clk);
  endtask
  task automatic cmd(input wbc_kind_t k, input logic [15:0] iv, input logic [15:0] cn,
                     input logic [15:0] ad);
    clr <= 1'b1;
    rx <= '0;
    // a zero count means the command gives none
    wcmd <= '{1'b1, k, iv, cn != 16'h0000, cn, ad};
    @(posedge clk);
    clr <= 1'b0;
    wcmd <= '0;
  endtask
  task automatic lst(input int n, input int base);
    str($sformatf("#L,%0d", n));
    for (int i = 0; i < n; i++) str($sformatf(",%0d", base + i));
    str("\015");
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    str("#I\015");
    idle();
    ck(seen.syn_err, 16'h0001);
    ck(16'(syn_code), 16'h000B);
    str("X\015");
    $display("test header done");
    cmd(K_DATA, 16'h0000, 16'h0003, 16'h0005);
    for (int i = 0; i < 7; i++) snd(8'({8'h23, 8'h41, 8'h00, 8'h03, 8'h11, 8'h22, 8'h33} >> (48 - 8 * i)));
    str("\015");
    idle();
    ck(seen.adapted, 16'h0001);
    ck(seen.bad_blk, 16'h0000);
    for (int i = 0; i < 3; i++) ck(i_buf.mem[5 + i], 16'(17 * (i + 1)));
    cmd(K_DATA, 16'h0002, 16'h0002, 16'h0014);
    str("#L,2,10,20\015");
    idle();
    for (int i = 0; i < 3; i++) ck(i_buf.mem[20 + i], 16'(10 + 5 * i));
    $display("test data done");
    foreach (bad[i])
    begin
      cmd(K_DATA, 16'h0001, 16'h0002, 16'h0028);
      str(bad[i]);
      idle();
      ck(seen.bad_blk, 16'h0001);
      str("#I\015");
    end
    ck(i_buf.mem[40], 16'h0007);
    $display("test errors done");
    // word values from here on, so descriptor range checks are reachable
    cfg_no_end <= 1'b0;
    cfg_word <= 1'b1;
    cmd(K_DESC, 16'h0001, 16'h0000, 16'h0000);
    lst(16, 1);
    str("#I\015");
    idle();
    ck(seen.desc_commit, 16'h0001);
    for (int i = 0; i < 16; i++) ck(desc_q[i], 16'(i + 1));
    for (int i = 0; i < 3; i++)
    begin
      cmd(K_DESC, 16'h0001, 16'h0000, 16'h0000);
      repeat (i == 2 ? 2 : 1) lst(i == 1 ? 15 : 16, i == 0 ? 32760 : 1);
      idle();
      ck(seen.bad_blk, 16'h0001);
      ck(desc_q[15], 16'h0010);
      str("#I\015");
    end
    cmd(K_TIME, 16'h0001, 16'h0000, 16'h0000);
    lst(7, 100);
    idle();
    ck(seen.bad_blk, 16'h0001);
    ck(time_q[0], 16'h0000);
    str("#I\015");
    cmd(K_TIME, 16'h0001, 16'h0000, 16'h0000);
    lst(8, 100);
    str("#I\015");
    idle();
    ck(time_q[7], 16'h006B);
    $display("test stored blocks done");
    cmd(K_DATA, 16'h0001, 16'h0003, 16'h0032);
    str("#L,2,1,2\015#I\015");
    idle();
    ck(seen.adapted, 16'h0001);
    cmd(K_DATA, 16'h0001, 16'h0003, 16'h0032);
    str("#L,1,1\015X\015");
    idle();
    ck(seen.bad_blk, 16'h0001);
    ck(seen.cmd_abort, 16'h0001);
    $display("test abort done");
    // full waveform: clamp reported only once the descriptor section ends
    cmd(K_ALL, 16'h0000, 16'h0000, 16'h7CFA);
    idle();
    ck(seen.adapted, 16'h0000);
    lst(16, 2);
    str("#I\015");
    idle();
    ck(seen.adapted, 16'h0001);
    ck(desc_q[0], 16'h0002);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    // no count given: six slots remain, five nominal values plus one
    lst(6, 300);
    str("#I\015");
    lst(8, 400);
    str("#I\015");
    idle();
    ck(seen.adapted, 16'h0000);
    ck(seen.bad_blk, 16'h0000);
    ck(time_q[0], 16'h0190);
    $display("test full waveform done");
    tally_and_finish();
  end
endmodule // waveform_block_write_checker_tb_top
